// ---- hw/mrl_pkg.sv ----
// Shared constants and carriers for the serial link control block.
// Assumes a 10 MHz system clock and a 32-bit classic Wishbone master.
package mrl_pkg;
  localparam int unsigned CLK_HZ      = 10000000;
  localparam int unsigned CLK_MHZ     = CLK_HZ / 1000000;
  localparam int unsigned MS_CYC      = CLK_HZ / 1000;
  localparam int unsigned PROC_US     = 50;
  localparam int unsigned PROC_CYC    = PROC_US * CLK_MHZ;
  // Register byte offsets
  localparam logic [7:0] A_FMT   = 8'h00;
  localparam logic [7:0] A_WAIT  = 8'h04;
  localparam logic [7:0] A_TMO   = 8'h08;
  localparam logic [7:0] A_BCAST = 8'h0C;
  localparam logic [7:0] A_AXIS  = 8'h10;
  localparam logic [7:0] A_PROT  = 8'h14;
  localparam logic [7:0] A_SPEED = 8'h18;
  localparam logic [7:0] A_STAT  = 8'h1C;
  localparam logic [7:0] A_MASK  = 8'h20;
  localparam logic [7:0] A_STATE = 8'h24;
  // Reset values
  localparam logic [15:0] R_FMT   = 16'h0000;
  localparam logic [15:0] R_WAIT  = 16'h0000;
  localparam logic [15:0] R_TMO   = 16'h0000;
  localparam logic [15:0] R_BCAST = 16'h0000;
  localparam logic [6:0]  R_AXIS  = 7'h01;
  localparam logic [1:0]  R_PROT  = 2'h0;
  localparam logic [2:0]  R_SPEED = 3'h2;
  localparam logic [2:0]  FMT_MAX = 3'h5;
  // Broadcast word bits
  localparam int B_REPLY = 0;
  localparam int B_NOPROC = 1;
  localparam int B_STRB = 2;
  localparam int B_USEWAIT = 3;
  // Status / mask bits
  localparam int S_FRAME = 0;
  localparam int S_TMO   = 1;
  localparam int S_TX    = 2;
  localparam int S_W     = 3;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  // Bit time in cycles per line speed code
  localparam logic [15:0] BIT_CYC [0:7] = '{16'(CLK_HZ / 2400), 16'(CLK_HZ / 4800),
    16'(CLK_HZ / 9600), 16'(CLK_HZ / 19200), 16'(CLK_HZ / 38400), 16'(CLK_HZ / 57600),
    16'(CLK_HZ / 115200), 16'(CLK_HZ / 230400)};
  typedef enum logic [2:0] {ST_IDLE, ST_RECV, ST_PROC, ST_WAIT, ST_SEND} mrl_state_t;
  typedef struct packed {
    logic parity_en;
    logic parity_odd;
    logic two_stop;
  } mrl_fmt_t;
endpackage : mrl_pkg

// ---- hw/mrl_link_ctrl.sv ----
// Link control of a serial slave: framing, reply timing, timeout, broadcast.
// Assumes a byte receiver and transmitter outside; Wishbone classic registers.
// Operation
// - Format code picks parity and stop bits.
// - Extra wait before reply, 0 to 10000 ms.
// - Reply always needs some processing delay.
// - Timeout error when own requests stop arriving; broadcast requests also restart the timeout here.
// - Timeout setting zero disables the error.
// - Broadcast: reply if bit0, process unless bit1.
// - Bit3 picks wait or timeout for delay.
// - Broadcast delay is axis times selected ms.
// - Broadcast bit1 set suppresses any reply.
// - Bit2 clears strobe at block start.
// - Axis 1 to 127; zero disables link.
// - Protocol selector: standard, point, multidrop; here code 0 (standard) keeps the link disabled, like unused code 3.
// - Speed code 0 to 7, default 9600.
// - Format and link settings apply at power-on.
//
// Added by the designer: the register addresses and register access over Wishbone.
module mrl_link_ctrl import mrl_pkg::*; #(
  parameter int unsigned MS_CYCLES = MS_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        power_on_i,
  input  wire logic        rx_char_i,
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        exercise_held_i,
  input  wire logic        block_start_i,
  output mrl_fmt_t         fmt_o,
  output logic      [2:0]  speed_o,
  output logic      [1:0]  protocol_o,
  output logic             link_en_o,
  output logic             req_process_o,
  output logic             tx_start_o,
  output logic             strobe_clear_o,
  output logic             comm_timeout_o,
  output logic             irq_o
);
  logic [15:0] link_char_format, response_extra_wait, link_timeout_time, broadcast_behaviour;
  logic [6:0]  axis_address_setting;
  logic [1:0]  protocol_selector;
  logic [2:0]  line_speed_selector;
  logic [S_W-1:0] irq_status, irq_mask, next_status;
  // Active copies, loaded only at power-on
  logic [2:0]  act_fmt;
  logic [6:0]  act_axis;
  logic [19:0] sil_lim;
  logic [19:0] sil_cnt;
  mrl_state_t  state;
  logic [7:0]  req_addr;
  logic        is_bcast, is_own, frame_end, want_reply, do_proc;
  logic [15:0] proc_cnt, ms_sub, tmo_sub;
  logic [20:0] wait_ms, wait_sel;
  logic [15:0] tmo_ms;
  logic        load_pend;
  logic        wr, rd_hit;
  logic [31:0] rd_data;

  // Write lands at the edge where the master samples ack high
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  // Bus slave: one wait state, unmapped reads zero, writes dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= rd_data;
    end
  end

  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h00000000;
    case (wb_adr_i)
      A_FMT:   rd_data[15:0] = link_char_format;
      A_WAIT:  rd_data[15:0] = response_extra_wait;
      A_TMO:   rd_data[15:0] = link_timeout_time;
      A_BCAST: rd_data[15:0] = broadcast_behaviour;
      A_AXIS:  rd_data[6:0]  = axis_address_setting;
      A_PROT:  rd_data[1:0]  = protocol_selector;
      A_SPEED: rd_data[2:0]  = line_speed_selector;
      A_STAT:  rd_data[S_W-1:0] = irq_status;
      A_MASK:  rd_data[S_W-1:0] = irq_mask;
      A_STATE: rd_data[10:0] = {link_en_o, act_axis, 3'(state)};
      default: rd_hit = 1'b0;
    endcase
  end

  // Stored settings; bits 4 to 15 of the broadcast word kept as written
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_char_format     <= R_FMT;
      response_extra_wait  <= R_WAIT;
      link_timeout_time    <= R_TMO;
      broadcast_behaviour  <= R_BCAST;
      axis_address_setting <= R_AXIS;
      protocol_selector    <= R_PROT;
      line_speed_selector  <= R_SPEED;
      irq_mask             <= '0;
    end else if (wr && rd_hit) begin
      case (wb_adr_i)
        A_FMT: begin
          if (wb_sel_i[0]) link_char_format[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) link_char_format[15:8] <= wb_dat_i[15:8];
        end
        A_WAIT: begin
          if (wb_sel_i[0]) response_extra_wait[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) response_extra_wait[15:8] <= wb_dat_i[15:8];
        end
        A_TMO: begin
          if (wb_sel_i[0]) link_timeout_time[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) link_timeout_time[15:8] <= wb_dat_i[15:8];
        end
        A_BCAST: begin
          if (wb_sel_i[0]) broadcast_behaviour[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) broadcast_behaviour[15:8] <= wb_dat_i[15:8];
        end
        A_AXIS:  if (wb_sel_i[0]) axis_address_setting <= wb_dat_i[6:0];
        A_PROT:  if (wb_sel_i[0]) protocol_selector <= wb_dat_i[1:0];
        A_SPEED: if (wb_sel_i[0]) line_speed_selector <= wb_dat_i[2:0];
        A_MASK:  if (wb_sel_i[0]) irq_mask <= wb_dat_i[S_W-1:0];
        default: ;
      endcase
    end
  end

  // Power-on load: a live rewrite must not disturb a frame in flight
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_pend  <= 1'b1;
      act_fmt    <= R_FMT[2:0];
      act_axis   <= R_AXIS;
      speed_o    <= R_SPEED;
      protocol_o <= R_PROT;
      fmt_o      <= '0;
      link_en_o  <= 1'b0;
      sil_lim    <= 20'hFFFFF;
    end else begin
      load_pend <= power_on_i;
      if (load_pend) begin
        // Out-of-range codes fall back to the default format
        act_fmt    <= (link_char_format > 16'(FMT_MAX)) ? R_FMT[2:0] : link_char_format[2:0];
        act_axis   <= axis_address_setting;
        speed_o    <= line_speed_selector;
        protocol_o <= protocol_selector;
      end
      fmt_o.parity_en  <= act_fmt < 3'h4;
      fmt_o.parity_odd <= act_fmt == 3'h2 || act_fmt == 3'h3;
      fmt_o.two_stop   <= act_fmt[0];
      link_en_o <= protocol_o != 2'h0 && protocol_o != 2'h3 && act_axis != 7'h00;
      // Start, 8 data, parity, stop bits, times 3.5
      sil_lim <= 20'((32'(BIT_CYC[speed_o]) * (32'd9 + 32'(fmt_o.parity_en)
                 + 32'(fmt_o.two_stop) + 32'd1) * 32'd7) >> 1);
    end
  end

  // A character on the closing cycle keeps the frame open
  assign frame_end = state == ST_RECV && !rx_char_i && sil_cnt >= sil_lim;
  assign is_bcast  = req_addr == BCAST_ADDR;
  assign is_own    = req_addr == {1'b0, act_axis};
  assign do_proc   = is_own || (is_bcast && !broadcast_behaviour[B_NOPROC]);
  assign want_reply = is_own || (is_bcast && broadcast_behaviour[B_REPLY]
                      && !broadcast_behaviour[B_NOPROC]);
  assign wait_sel  = broadcast_behaviour[B_USEWAIT] ? 21'(response_extra_wait)
                     : 21'(link_timeout_time);

  // Frame receive, processing delay, reply wait
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state         <= ST_IDLE;
      sil_cnt       <= '0;
      req_addr      <= '0;
      proc_cnt      <= '0;
      ms_sub        <= '0;
      wait_ms       <= '0;
      req_process_o <= 1'b0;
      tx_start_o    <= 1'b0;
    end else begin
      req_process_o <= 1'b0;
      tx_start_o    <= 1'b0;
      sil_cnt <= rx_char_i ? 20'h00000 : (sil_cnt == 20'hFFFFF ? sil_cnt : sil_cnt + 20'h00001);
      case (state)
        ST_IDLE: if (rx_char_i && link_en_o) begin
          req_addr <= rx_byte_i;
          state    <= ST_RECV;
        end
        ST_RECV: if (frame_end) begin
          req_process_o <= do_proc && (is_own || is_bcast);
          proc_cnt      <= '0;
          ms_sub        <= '0;
          // Broadcast answers are staggered by axis number
          wait_ms <= is_bcast ? 21'(21'(act_axis) * wait_sel) : 21'(response_extra_wait);
          state   <= want_reply ? ST_PROC : ST_IDLE;
        end
        ST_PROC: begin
          proc_cnt <= proc_cnt + 16'h0001;
          if (proc_cnt >= 16'(PROC_CYC - 1)) state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (wait_ms == 21'h000000) begin
            state <= ST_SEND;
          end else if (ms_sub >= 16'(MS_CYCLES - 1)) begin
            ms_sub  <= '0;
            wait_ms <= wait_ms - 21'h000001;
          end else begin
            ms_sub <= ms_sub + 16'h0001;
          end
        end
        ST_SEND: begin
          tx_start_o <= 1'b1;
          state      <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Timeout supervision while exercise right is held
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmo_sub <= '0;
      tmo_ms  <= '0;
    end else if (!exercise_held_i || (frame_end && (is_own || is_bcast))) begin
      tmo_sub <= '0;
      tmo_ms  <= '0;
    end else if (tmo_sub >= 16'(MS_CYCLES - 1)) begin
      tmo_sub <= '0;
      if (tmo_ms != 16'hFFFF) tmo_ms <= tmo_ms + 16'h0001;
    end else begin
      tmo_sub <= tmo_sub + 16'h0001;
    end
  end

  // Sticky events: a new event beats a same-cycle clear
  always_comb begin
    next_status = irq_status;
    if (wr && wb_adr_i == A_STAT && wb_sel_i[0]) next_status = next_status & ~wb_dat_i[S_W-1:0];
    if (frame_end) next_status[S_FRAME] = 1'b1;
    if (exercise_held_i && link_timeout_time != 16'h0000 && tmo_ms >= link_timeout_time)
      next_status[S_TMO] = 1'b1;
    if (state == ST_SEND) next_status[S_TX] = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status     <= '0;
      irq_o          <= 1'b0;
      comm_timeout_o <= 1'b0;
    end else begin
      irq_status     <= next_status;
      irq_o          <= |(next_status & irq_mask);
      comm_timeout_o <= next_status[S_TMO];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) strobe_clear_o <= 1'b0;
    else strobe_clear_o <= block_start_i && broadcast_behaviour[B_STRB];
  end

  property p_fmt;
    @(posedge clk_i) disable iff (rst_i)
    act_fmt == 3'h4 |=> !fmt_o.parity_en && !fmt_o.two_stop;
  endproperty
  a_fmt: assert property (p_fmt) else $error("format code 4 gave wrong framing");

  property p_proc_gap;
    @(posedge clk_i) disable iff (rst_i)
    frame_end |=> !tx_start_o [*3];
  endproperty
  a_proc_gap: assert property (p_proc_gap) else $error("reply started without processing delay");

  property p_wait_load;
    @(posedge clk_i) disable iff (rst_i)
    frame_end && is_own |=> wait_ms == 21'($past(response_extra_wait)) && state == ST_PROC;
  endproperty
  a_wait_load: assert property (p_wait_load) else $error("own reply wait not loaded");

  property p_tmo_off;
    @(posedge clk_i) disable iff (rst_i)
    link_timeout_time == 16'h0000 && !irq_status[S_TMO] |=> !irq_status[S_TMO];
  endproperty
  a_tmo_off: assert property (p_tmo_off) else $error("timeout raised with zero setting");

  property p_tmo_reset;
    @(posedge clk_i) disable iff (rst_i)
    exercise_held_i && frame_end && is_own |=> tmo_ms == 16'h0000;
  endproperty
  a_tmo_reset: assert property (p_tmo_reset) else $error("own request did not restart timeout");

  property p_bc_proc;
    @(posedge clk_i) disable iff (rst_i)
    frame_end && is_bcast |=> req_process_o == !$past(broadcast_behaviour[B_NOPROC]);
  endproperty
  a_bc_proc: assert property (p_bc_proc) else $error("broadcast processing flag ignored");

  property p_bc_silent;
    @(posedge clk_i) disable iff (rst_i)
    frame_end && is_bcast && broadcast_behaviour[B_NOPROC] |=> state == ST_IDLE ##1 !tx_start_o;
  endproperty
  a_bc_silent: assert property (p_bc_silent) else $error("broadcast reply despite bit1");

  property p_bc_delay;
    @(posedge clk_i) disable iff (rst_i)
    frame_end && is_bcast && want_reply |=> wait_ms == 21'(21'(act_axis) * $past(wait_sel));
  endproperty
  a_bc_delay: assert property (p_bc_delay) else $error("broadcast delay not axis times setting");

  property p_strobe;
    @(posedge clk_i) disable iff (rst_i)
    block_start_i |=> strobe_clear_o == $past(broadcast_behaviour[B_STRB]);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe auto clear mismatch");

  property p_axis0;
    @(posedge clk_i) disable iff (rst_i)
    act_axis == 7'h00 |=> !link_en_o;
  endproperty
  a_axis0: assert property (p_axis0) else $error("link enabled with axis zero");

  property p_silence;
    @(posedge clk_i) disable iff (rst_i)
    rx_char_i && state == ST_RECV |=> state == ST_RECV;
  endproperty
  a_silence: assert property (p_silence) else $error("frame ended while characters arrive");

  property p_prot_off;
    @(posedge clk_i) disable iff (rst_i)
    protocol_o == 2'h3 |=> !link_en_o;
  endproperty
  a_prot_off: assert property (p_prot_off) else $error("link enabled with unused protocol code");

  property p_tmo_set;
    @(posedge clk_i) disable iff (rst_i)
    exercise_held_i && link_timeout_time != 16'h0000 && tmo_ms >= link_timeout_time
      |=> irq_status[S_TMO] && comm_timeout_o;
  endproperty
  a_tmo_set: assert property (p_tmo_set) else $error("timeout elapsed but error not raised");
endmodule : mrl_link_ctrl

// ---- sim/mrl_host_model.sv ----
// Stand-in for the bus master: sends request characters to the link block.
// Assumes the block samples rx_char_i and rx_byte_i on rising edges of clk_i.
module mrl_host_model #(
  parameter int unsigned GAP = 430
) (
  input  wire logic       clk_i,
  output logic            rx_char_o,
  output logic      [7:0] rx_byte_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rx_char_o = 1'b0;
    rx_byte_o = 8'hA5;
  end
  // Spacing well under 3.5 characters; the silence afterwards ends the frame
  task automatic send_frame(input logic [7:0] adr, input int n);
    logic [7:0] b;
    for (int i = 0; i <= n; i++) begin
      b = (i == 0) ? adr : 8'($urandom);
      @(posedge clk_i);
      rx_char_o <= 1'b1;
      rx_byte_o <= b;
      @(posedge clk_i);
      rx_char_o <= 1'b0;
      // Idle line must not keep showing the last byte
      rx_byte_o <= ~b;
      repeat (GAP) @(posedge clk_i);
    end
  endtask : send_frame
endmodule : mrl_host_model

// ---- sim/test_modbus_rtu_slave_link_control.sv ----
// Self-checking bench for the serial link control block.
// Assumes mrl_pkg, mrl_link_ctrl and the host model are compiled first.
module test_modbus_rtu_slave_link_control import mrl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MS = 10;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, power_on = 1'b0;
  logic held = 1'b0, blk = 1'b0, ack, rx_char, link_en, req, tx, strb, tmo, irq;
  logic [7:0] adr = 8'h00, rx_byte;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat, q;
  logic [2:0] speed;
  logic [1:0] prot;
  logic [3:0] bc;
  mrl_fmt_t fmt;
  int failures, n_checks, n_req, n_tx, n_strb, cyc_n, t_req, t_tx, w, s, sr, prev, gap, d;
  logic [31:0] rst_v [7] = '{32'(R_FMT), 32'(R_WAIT), 32'(R_TMO), 32'(R_BCAST), 32'(R_AXIS),
    32'(R_PROT), 32'(R_SPEED)};
  logic [3:0] modes [4] = '{4'h9, 4'h1, 4'h3, 4'h0};
  mrl_link_ctrl #(.MS_CYCLES(MS)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .power_on_i(power_on), .rx_char_i(rx_char), .rx_byte_i(rx_byte), .exercise_held_i(held),
    .block_start_i(blk), .fmt_o(fmt), .speed_o(speed), .protocol_o(prot), .link_en_o(link_en),
    .req_process_o(req), .tx_start_o(tx), .strobe_clear_o(strb), .comm_timeout_o(tmo), .irq_o(irq));
  mrl_host_model #(.GAP(430)) u_host (.clk_i(clk_i), .rx_char_o(rx_char), .rx_byte_o(rx_byte));
  always #50 clk_i = ~clk_i;
  // Pulse outputs are only one cycle wide, so count them at every edge
  always @(posedge clk_i) begin
    cyc_n++;
    if (req === 1'b1) begin
      n_req++;
      t_req = cyc_n;
    end
    if (tx === 1'b1) begin
      n_tx++;
      t_tx = cyc_n;
    end
    if (strb === 1'b1) n_strb++;
  end
  function automatic mrl_fmt_t exp_fmt(input int c);
    mrl_fmt_t f;
    f.parity_en = (c < 4);
    f.parity_odd = (c == 2 || c == 3);
    f.two_stop = c[0];
    return f;
  endfunction : exp_fmt
  function automatic int bc_delay(input logic [3:0] m, input int wt);
    return 3 * (m[3] ? wt : 2) * MS;
  endfunction : bc_delay
  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] dv, output logic [31:0] rv);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    dat <= dv;
    sel <= 4'h3;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) begin
      failures++;
      summarize();
    end
    rv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic pwr;
    @(posedge clk_i);
    power_on <= 1'b1;
    @(posedge clk_i);
    power_on <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : pwr
  task automatic wait_tx(input int st);
    int k;
    for (k = 0; k < 5000 && n_tx == st; k++) @(posedge clk_i);
    if (n_tx == st) begin
      failures++;
      summarize();
    end
  endtask : wait_tx
  initial begin
    void'($urandom(32'h9d54));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(32'(link_en), 32'h0);
    chk(32'(speed), 32'h2);
    chk(32'(prot), 32'h0);
    for (int i = 0; i < 7; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0, q);
      chk(q, rst_v[i]);
    end
    // Unmapped place: write ignored, reads zero
    wb(1'b1, 8'h30, 32'hFFFF, q);
    wb(1'b0, 8'h30, 32'h0, q);
    chk(q, 32'h0);
    prev = 0;
    for (int c = 0; c < 6; c++) begin
      wb(1'b1, A_FMT, 32'(c), q);
      chk(32'(fmt), 32'(exp_fmt(prev)));
      pwr();
      chk(32'(fmt), 32'(exp_fmt(c)));
      prev = c;
    end
    wb(1'b1, A_FMT, 32'h4, q);
    wb(1'b1, A_SPEED, 32'h7, q);
    wb(1'b1, A_AXIS, 32'h3, q);
    wb(1'b1, A_PROT, 32'h2, q);
    pwr();
    chk(32'(link_en), 32'h1);
    chk(32'(speed), 32'h7);
    chk(32'(prot), 32'h2);
    w = 1 + 2 * $urandom_range(0, 1);
    wb(1'b1, A_WAIT, 32'(w), q);
    wb(1'b1, A_TMO, 32'h2, q);
    s = n_tx;
    sr = n_req;
    u_host.send_frame(8'h03, 2);
    wait_tx(s);
    chk(32'(n_req - sr), 32'h1);
    gap = t_tx - t_req;
    chk(32'(gap >= PROC_CYC + w * MS - 2 && gap <= PROC_CYC + w * MS + 4), 32'h1);
    sr = n_req;
    u_host.send_frame(8'h05, 1);
    repeat (2500) @(posedge clk_i);
    chk(32'(n_req - sr), 32'h0);
    foreach (modes[i]) begin
      bc = modes[i];
      wb(1'b1, A_BCAST, {28'h0, bc}, q);
      sr = n_req;
      s = n_tx;
      u_host.send_frame(BCAST_ADDR, 1);
      repeat (2800) @(posedge clk_i);
      chk(32'(n_req - sr), bc[1] ? 32'h0 : 32'h1);
      chk(32'(n_tx - s), (bc[0] && !bc[1]) ? 32'h1 : 32'h0);
      d = bc_delay(bc, w);
      gap = t_tx - t_req;
      if (n_tx != s) chk(32'(gap >= PROC_CYC + d && gap <= PROC_CYC + d + 4), 32'h1);
    end
    for (int b = 0; b < 2; b++) begin
      wb(1'b1, A_BCAST, 32'(b << 2), q);
      s = n_strb;
      @(posedge clk_i);
      blk <= 1'b1;
      @(posedge clk_i);
      blk <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk(32'(n_strb - s), 32'(b));
    end
    wb(1'b1, A_MASK, 32'(1 << S_TMO), q);
    @(posedge clk_i);
    held <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(32'(tmo), 32'h0);
    for (int k = 0; k < 40 && tmo !== 1'b1; k++) @(posedge clk_i);
    chk(32'(tmo), 32'h1);
    chk(32'(irq), 32'h1);
    held <= 1'b0;
    wb(1'b1, A_STAT, 32'(1 << S_TMO), q);
    wb(1'b0, A_STAT, 32'h0, q);
    chk(32'(q[S_TMO]), 32'h0);
    // Frame and reply bits are still set but masked
    chk(32'(irq), 32'h0);
    wb(1'b1, A_TMO, 32'h0, q);
    held <= 1'b1;
    repeat (60) @(posedge clk_i);
    chk(32'(tmo), 32'h0);
    held <= 1'b0;
    for (int p = 0; p < 4; p++) begin
      wb(1'b1, A_PROT, 32'(p), q);
      pwr();
      chk(32'(prot), 32'(p));
      chk(32'(link_en), (p == 1 || p == 2) ? 32'h1 : 32'h0);
    end
    wb(1'b1, A_PROT, 32'h2, q);
    wb(1'b1, A_AXIS, 32'h0, q);
    pwr();
    chk(32'(link_en), 32'h0);
    summarize();
  end
endmodule : test_modbus_rtu_slave_link_control
